// File: rtl/ebac_top.sv
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ps
module ebac_top (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic mode_8bit_default_i,
	input wire logic mode_16m_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [15:0] wb_adr_i,
	input wire logic [7:0] wb_dat_i,
	input wire logic [0:0] wb_sel_i,
	output logic [7:0] wb_dat_o,
	output logic wb_ack_o,
	// Internal access request
	input wire logic acc_req_i,
	input wire logic acc_we_i,
	input wire logic [23:0] acc_addr_i,
	input wire logic acc_upper_i,
	input wire logic acc_lower_i,
	output logic acc_done_o,
	input wire logic dma_req_i,
	input wire logic refresh_req_i,
	output logic [1:0] bus_owner_o,
	// External pins
	output logic [23:0] ext_addr_o,
	output logic [7:0] area_select_n_o,
	output logic addr_strobe_n_o,
	output logic read_strobe_n_o,
	output logic upper_write_strobe_n_o,
	output logic lower_write_strobe_n_o,
	input wire logic wait_req_n_i,
	input wire logic ext_bus_request_n_i,
	output logic ext_bus_ack_n_o,
	output logic bus_8bit_mode_o,
	output logic req_pins_as_io_o
);
	// ==========================================
	// Registers
	logic [7:0] area_byte_width;
	logic [7:0] area_three_state;
	logic [1:0] wait_mode_sel;
	logic [1:0] wait_count;
	logic [7:0] area_wait_ctl_en;
	logic bus_release_en;
	logic reset_seen;
	logic wb_hit;
	logic wb_wr;

	// Pin synchronisers
	logic [1:0] wait_sync;
	logic [1:0] ext_bus_request_n_sync;
	logic wait_active;
	logic ext_bus_request_n_active;

	// Access sequencer
	typedef enum logic [2:0] {
		EBAC_IDLE = 3'b000,
		EBAC_T1 = 3'b001,
		EBAC_T2 = 3'b010,
		EBAC_TW = 3'b011,
		EBAC_T3 = 3'b100,
		EBAC_INT = 3'b101,
		EBAC_REL = 3'b110
	} ebac_state_t;
	ebac_state_t state;
	ebac_state_t next_state;
	logic [2:0] area;
	logic onchip;
	logic cur_we;
	logic cur_upper;
	logic cur_lower;
	logic cur_3state;
	logic cur_8bit;
	logic [1:0] waits_left;
	logic [1:0] int_cnt;
	ebac_pkg::ebac_owner_t owner;

	// Area index from address, by address space size
	function automatic logic [2:0] ebac_area_of(input logic [23:0] a, input logic m16);
		ebac_area_of = m16 ? a[ebac_pkg::AREA_LSB_16M +: 3] : a[ebac_pkg::AREA_LSB_1M +: 3];
	endfunction : ebac_area_of

	// Top 4 kB of either space is on-chip memory and registers
	function automatic logic ebac_is_onchip(input logic [23:0] a, input logic m16);
		ebac_is_onchip = m16 ? (a >= ebac_pkg::ONCHIP_BASE_16M) :
			(a[19:0] >= ebac_pkg::ONCHIP_BASE_1M[19:0]);
	endfunction : ebac_is_onchip

	assign wait_active = ~wait_sync[1];
	assign ext_bus_request_n_active = ~ext_bus_request_n_sync[1];

	// ==========================================
	// Wishbone slave: one-cycle ack, byte lane 0 only
	assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wb_wr = wb_hit & wb_we_i & wb_sel_i[0];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_hit;
		end
	end

	// Read data; unmapped addresses read zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 8'h00;
		end else if (wb_hit) begin
			case (wb_adr_i)
				ebac_pkg::ADDR_AREA_WIDTH_SELECT: wb_dat_o <= area_byte_width;
				ebac_pkg::ADDR_AREA_ACCESS_LENGTH: wb_dat_o <= area_three_state;
				ebac_pkg::ADDR_WAIT_MODE_CONTROL: wb_dat_o <= ebac_pkg::WAIT_MODE_RO_ONES |
					{4'h0, wait_mode_sel, wait_count};
				ebac_pkg::ADDR_WAIT_CTL_AREA_EN: wb_dat_o <= area_wait_ctl_en;
				ebac_pkg::ADDR_BUS_RELEASE_CONTROL: wb_dat_o <= ebac_pkg::BUS_RELEASE_RO_ONES |
					{7'h00, bus_release_en};
				ebac_pkg::ADDR_BUS_STATUS: wb_dat_o <= {3'h0, state, owner};
				default: wb_dat_o <= 8'h00;
			endcase
		end
	end

	// width reset by mode strap, caught after release; written over Wishbone otherwise
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			reset_seen <= 1'b1;
			area_byte_width <= ebac_pkg::RST_WIDTH_16BIT;
		end else if (reset_seen) begin
			reset_seen <= 1'b0;
			area_byte_width <= mode_8bit_default_i ? ebac_pkg::RST_WIDTH_8BIT :
				ebac_pkg::RST_WIDTH_16BIT;
		end else if (wb_wr && wb_adr_i == ebac_pkg::ADDR_AREA_WIDTH_SELECT) begin
			area_byte_width <= wb_dat_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			area_three_state <= ebac_pkg::RST_ACCESS_LENGTH;
		end else if (wb_wr && wb_adr_i == ebac_pkg::ADDR_AREA_ACCESS_LENGTH) begin
			area_three_state <= wb_dat_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wait_mode_sel <= ebac_pkg::RST_WAIT_MODE[ebac_pkg::WMS_LSB +: 2];
			wait_count <= ebac_pkg::RST_WAIT_MODE[ebac_pkg::WC_LSB +: 2];
		end else if (wb_wr && wb_adr_i == ebac_pkg::ADDR_WAIT_MODE_CONTROL) begin
			wait_mode_sel <= wb_dat_i[ebac_pkg::WMS_LSB +: 2];
			wait_count <= wb_dat_i[ebac_pkg::WC_LSB +: 2];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			area_wait_ctl_en <= ebac_pkg::RST_WAIT_CTL_EN;
		end else if (wb_wr && wb_adr_i == ebac_pkg::ADDR_WAIT_CTL_AREA_EN) begin
			area_wait_ctl_en <= wb_dat_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus_release_en <= ebac_pkg::RST_BUS_RELEASE[ebac_pkg::BUS_RELEASE_EN_BIT];
		end else if (wb_wr && wb_adr_i == ebac_pkg::ADDR_BUS_RELEASE_CONTROL) begin
			bus_release_en <= wb_dat_i[ebac_pkg::BUS_RELEASE_EN_BIT];
		end
	end

	// eight-bit bus mode when every area is 8-bit
	assign bus_8bit_mode_o = &area_byte_width;
	// request pins free for I/O while release disabled
	assign req_pins_as_io_o = ~bus_release_en;

	// ==========================================
	// Two-flop synchronisers for pins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wait_sync <= 2'b11;
			ext_bus_request_n_sync <= 2'b11;
		end else begin
			wait_sync <= {wait_sync[0], wait_req_n_i};
			ext_bus_request_n_sync <= {ext_bus_request_n_sync[0], ext_bus_request_n_i};
		end
	end

	// ==========================================
	// Sequencer next state
	always_comb begin
		next_state = state;
		case (state)
			EBAC_IDLE: begin
				if (bus_release_en && ext_bus_request_n_active) begin
					next_state = EBAC_REL;
				// Request still stands in the done cycle; taking it would repeat the access
				end else if (acc_req_i && !acc_done_o && owner != ebac_pkg::EBAC_OWN_EXT) begin
					next_state = ebac_is_onchip(acc_addr_i, mode_16m_i) ? EBAC_INT : EBAC_T1;
				end
			end
			EBAC_T1: next_state = EBAC_T2;
			EBAC_T2: begin
				if (!cur_3state) begin
					next_state = EBAC_IDLE;
				end else if (waits_left != 2'd0) begin
					next_state = EBAC_TW;
				end else if (area_wait_ctl_en[area] == 1'b0 || wait_mode_sel[1]) begin
					// pin wait sampled only in three-state areas
					next_state = wait_active ? EBAC_TW : EBAC_T3;
				end else begin
					next_state = EBAC_T3;
				end
			end
			EBAC_TW: begin
				// extend while pin wait held after programmed waits
				if (waits_left > 2'd1) begin
					next_state = EBAC_TW;
				end else if ((area_wait_ctl_en[area] == 1'b0 || wait_mode_sel[1]) &&
					wait_active) begin
					next_state = EBAC_TW;
				end else begin
					next_state = EBAC_T3;
				end
			end
			EBAC_T3: next_state = EBAC_IDLE;
			EBAC_INT: next_state = (int_cnt == 2'(ebac_pkg::ONCHIP_STATES - 1)) ? EBAC_IDLE :
				EBAC_INT;
			EBAC_REL: next_state = (ext_bus_request_n_active && bus_release_en) ? EBAC_REL : EBAC_IDLE;
			default: next_state = EBAC_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= EBAC_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Latch access attributes at start; width and three-state changes mid-access apply next time
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			area <= 3'd0;
			onchip <= 1'b0;
			cur_we <= 1'b0;
			cur_upper <= 1'b0;
			cur_lower <= 1'b0;
			cur_3state <= 1'b0;
			cur_8bit <= 1'b0;
			ext_addr_o <= 24'h000000;
		end else if (state == EBAC_IDLE && (next_state == EBAC_T1 || next_state == EBAC_INT)) begin
			area <= ebac_area_of(acc_addr_i, mode_16m_i);
			onchip <= (next_state == EBAC_INT);
			cur_we <= acc_we_i;
			// width bit latched for on-chip accesses too; only the external write strobes use it
			cur_8bit <= area_byte_width[ebac_area_of(acc_addr_i, mode_16m_i)];
			cur_upper <= acc_upper_i;
			cur_lower <= acc_lower_i;
			cur_3state <= area_three_state[ebac_area_of(acc_addr_i, mode_16m_i)];
			ext_addr_o <= acc_addr_i;
		end
	end

	// programmed waits in every mode but no-wait, with control enabled
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			waits_left <= 2'd0;
		end else if (state == EBAC_T1) begin
			if (area_wait_ctl_en[area] && (wait_mode_sel == ebac_pkg::EBAC_WAIT_PROG ||
				wait_mode_sel == ebac_pkg::EBAC_WAIT_AUTO ||
				wait_mode_sel == ebac_pkg::EBAC_WAIT_PIN1)) begin
				waits_left <= wait_count;
			end else begin
				waits_left <= 2'd0;
			end
		end else if (state == EBAC_TW && waits_left != 2'd0) begin
			waits_left <= waits_left - 2'd1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			int_cnt <= 2'd0;
		end else if (state == EBAC_INT) begin
			int_cnt <= int_cnt + 2'd1;
		end else begin
			int_cnt <= 2'd0;
		end
	end

	// arbiter: external > refresh > dma > cpu, changes only between accesses
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			owner <= ebac_pkg::EBAC_OWN_CPU;
		end else if (next_state == EBAC_REL) begin
			owner <= ebac_pkg::EBAC_OWN_EXT;
		end else if (next_state == EBAC_IDLE) begin
			if (refresh_req_i) begin
				owner <= ebac_pkg::EBAC_OWN_REFRESH;
			end else if (dma_req_i) begin
				owner <= ebac_pkg::EBAC_OWN_DMA;
			end else begin
				owner <= ebac_pkg::EBAC_OWN_CPU;
			end
		end
	end
	assign bus_owner_o = owner;

	// ==========================================
	// Pin strobes, registered from next state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			area_select_n_o <= 8'hff;
			addr_strobe_n_o <= 1'b1;
			read_strobe_n_o <= 1'b1;
			upper_write_strobe_n_o <= 1'b1;
			lower_write_strobe_n_o <= 1'b1;
			ext_bus_ack_n_o <= 1'b1;
			acc_done_o <= 1'b0;
		end else begin
			// area select; on-chip uses area 7
			area_select_n_o <= 8'hff;
			if (state == EBAC_INT) begin
				area_select_n_o[7] <= 1'b0;
			end else if (state inside {EBAC_T1, EBAC_T2, EBAC_TW, EBAC_T3} &&
				next_state != EBAC_IDLE) begin
				area_select_n_o[area] <= 1'b0;
			end
			// address strobe through the external access
			addr_strobe_n_o <= ~(state inside {EBAC_T1, EBAC_T2, EBAC_TW} &&
				next_state != EBAC_IDLE);
			read_strobe_n_o <= ~(!cur_we && !onchip && state inside {EBAC_T1, EBAC_T2, EBAC_TW} &&
				next_state != EBAC_IDLE);
			// upper strobe; 8-bit areas use upper lane
			upper_write_strobe_n_o <= ~(cur_we && (cur_upper || cur_8bit) &&
				state inside {EBAC_T2, EBAC_TW} && next_state != EBAC_IDLE);
			// lower strobe only on 16-bit areas
			lower_write_strobe_n_o <= ~(cur_we && cur_lower && !cur_8bit &&
				state inside {EBAC_T2, EBAC_TW} && next_state != EBAC_IDLE);
			ext_bus_ack_n_o <= ~(next_state == EBAC_REL);
			acc_done_o <= (state != EBAC_IDLE && state != EBAC_REL && next_state == EBAC_IDLE);
		end
	end
endmodule : ebac_top

// File: rtl/ebac_pkg.sv
package ebac_pkg;
	// ==========================================
	// Register byte addresses (low 16 bits of the printed address)
	localparam logic [15:0] ADDR_AREA_WIDTH_SELECT = 16'hffec;
	localparam logic [15:0] ADDR_AREA_ACCESS_LENGTH = 16'hffed;
	localparam logic [15:0] ADDR_WAIT_MODE_CONTROL = 16'hffee;
	localparam logic [15:0] ADDR_WAIT_CTL_AREA_EN = 16'hffef;
	localparam logic [15:0] ADDR_BUS_RELEASE_CONTROL = 16'hfff3;
	localparam logic [15:0] ADDR_BUS_STATUS = 16'hfff4;
	// ==========================================
	// Reset values
	localparam logic [7:0] RST_WIDTH_8BIT = 8'hff;
	localparam logic [7:0] RST_WIDTH_16BIT = 8'h00;
	localparam logic [7:0] RST_ACCESS_LENGTH = 8'hff;
	localparam logic [7:0] RST_WAIT_MODE = 8'hf3;
	localparam logic [7:0] RST_WAIT_CTL_EN = 8'hff;
	localparam logic [7:0] RST_BUS_RELEASE = 8'hfe;
	// ==========================================
	// Field positions and fixed bits
	localparam int WMS_LSB = 2;
	localparam int WC_LSB = 0;
	localparam int BUS_RELEASE_EN_BIT = 0;
	localparam logic [7:0] WAIT_MODE_RO_ONES = 8'hf0;
	localparam logic [7:0] BUS_RELEASE_RO_ONES = 8'hfe;
	// ==========================================
	// Address area decode
	localparam int AREA_LSB_1M = 17;
	localparam int AREA_LSB_16M = 21;
	localparam logic [23:0] ONCHIP_BASE_1M = 24'h0ff000;
	localparam logic [23:0] ONCHIP_BASE_16M = 24'hfff000;
	localparam int ONCHIP_STATES = 2;
	// Wait mode encodings
	typedef enum logic [1:0] {
		EBAC_WAIT_PROG = 2'b00,
		EBAC_WAIT_NONE = 2'b01,
		EBAC_WAIT_PIN1 = 2'b10,
		EBAC_WAIT_AUTO = 2'b11
	} ebac_wait_mode_t;
	// Bus owners
	typedef enum logic [1:0] {
		EBAC_OWN_CPU = 2'b00,
		EBAC_OWN_DMA = 2'b01,
		EBAC_OWN_REFRESH = 2'b10,
		EBAC_OWN_EXT = 2'b11
	} ebac_owner_t;
endpackage : ebac_pkg

// File: tb/ebac_top_assertions.sv
`timescale 1ns/1ps
module ebac_top_chk (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic mode_16m_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic acc_req_i,
	input wire logic [23:0] acc_addr_i,
	input wire logic acc_done_o,
	input wire logic [1:0] bus_owner_o,
	input wire logic [23:0] ext_addr_o,
	input wire logic [7:0] area_select_n_o,
	input wire logic addr_strobe_n_o,
	input wire logic read_strobe_n_o,
	input wire logic upper_write_strobe_n_o,
	input wire logic lower_write_strobe_n_o,
	input wire logic ext_bus_request_n_i,
	input wire logic ext_bus_ack_n_o,
	input wire logic req_pins_as_io_o
);
	// ==========================================
	// Area index of the driven address, by mode
	logic [2:0] area_idx;
	assign area_idx = mode_16m_i ? ext_addr_o[23:21] : ext_addr_o[19:17];
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ==========================================
	// Properties
	a_one_select: assert property ($onehot0(~area_select_n_o))
		else $error("more than one area select low");
	a_area_decode: assert property (!addr_strobe_n_o |-> !area_select_n_o[area_idx])
		else $error("area select does not match address");
	a_rw_apart: assert property (!read_strobe_n_o |->
		upper_write_strobe_n_o && lower_write_strobe_n_o)
		else $error("read and write strobes low together");
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("register access not acknowledged");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("acknowledge longer than one cycle");
	a_done_pulse: assert property (acc_done_o |=> !acc_done_o)
		else $error("access done longer than one cycle");
	a_io_no_ack: assert property (req_pins_as_io_o |-> ext_bus_ack_n_o)
		else $error("bus acknowledged while release disabled");
	a_ack_owner: assert property (!ext_bus_ack_n_o |-> bus_owner_o == 2'h3)
		else $error("bus acknowledged but not owned outside");
	a_ack_drop: assert property (ext_bus_request_n_i [*5] |-> ext_bus_ack_n_o)
		else $error("acknowledge held after request ended");
	a_onchip_quiet: assert property (acc_req_i && mode_16m_i &&
		acc_addr_i[23:12] == 12'hfff
		|=> addr_strobe_n_o && read_strobe_n_o && upper_write_strobe_n_o
		&& lower_write_strobe_n_o)
		else $error("strobe active during on-chip access");
endmodule : ebac_top_chk
bind ebac_top ebac_top_chk u_chk (.*);

// File: tb/ebac_ext_model.sv
`timescale 1ns/1ps
module ebac_ext_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic addr_strobe_n_i,
	input wire logic [3:0] stall_len_i,
	input wire logic want_bus_i,
	output logic wait_req_n_o,
	output logic bus_request_n_o
);
	logic [3:0] left;
	logic as_q;
	// Slow device stretches an access on command; pulled-up line idles high
	always_ff @(posedge clk_i) begin
		as_q <= addr_strobe_n_i;
		if (rst_i)
			left <= 4'h0;
		else if (as_q && !addr_strobe_n_i)
			left <= stall_len_i;
		else if (left != 4'h0)
			left <= left - 4'h1;
	end
	// Wait goes low as soon as the strobe falls, so it gets through the synchroniser in time
	assign wait_req_n_o = (left == 4'h0) &&
		!(as_q && !addr_strobe_n_i && stall_len_i != 4'h0);
	// External master asks for the bus, clocked like any other pin
	always_ff @(posedge clk_i) begin
		bus_request_n_o <= rst_i | !want_bus_i;
	end
endmodule : ebac_ext_model

// File: tb/ebac_top_tb.sv
`timescale 1ns/1ps
module ebac_top_tb;
	typedef struct packed {logic we; logic [15:0] a; logic [7:0] d; logic [7:0] e;} ebac_row_t;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic mode_8bit_default_i = 1'b1;
	logic mode_16m_i = 1'b1;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [15:0] wb_adr_i = 16'h0000;
	logic [7:0] wb_dat_i = 8'h00;
	logic [0:0] wb_sel_i = 1'b0;
	logic acc_req_i = 1'b0, acc_we_i = 1'b0, acc_upper_i = 1'b0, acc_lower_i = 1'b0;
	logic [23:0] acc_addr_i = 24'h000000;
	logic dma_req_i = 1'b0, refresh_req_i = 1'b0;
	logic [3:0] stall_len = 4'h0;
	logic want_bus = 1'b0;
	logic [7:0] wb_dat_o, area_select_n_o, q;
	logic [23:0] ext_addr_o;
	logic [1:0] bus_owner_o;
	logic wb_ack_o, acc_done_o, addr_strobe_n_o, read_strobe_n_o, upper_write_strobe_n_o;
	logic lower_write_strobe_n_o, wait_req_n_i, ext_bus_request_n_i, ext_bus_ack_n_o;
	logic bus_8bit_mode_o, req_pins_as_io_o, seen_rd, seen_up, seen_lo, seen_sel7;
	int failures = 0, cmp_count = 0, n, n2;
	// Registers: reads expect e, writes leave e unused
	ebac_row_t rows [15] = '{
		{1'b0, 16'hffec, 8'h00, 8'hff}, {1'b0, 16'hffed, 8'h00, 8'hff},
		{1'b0, 16'hffee, 8'h00, 8'hf3}, {1'b0, 16'hffef, 8'h00, 8'hff},
		{1'b0, 16'hfff3, 8'h00, 8'hfe}, {1'b1, 16'hffe0, 8'h5a, 8'h00},
		{1'b0, 16'hffe0, 8'h00, 8'h00}, {1'b1, 16'hffee, 8'h00, 8'h00},
		{1'b0, 16'hffee, 8'h00, 8'hf0}, {1'b1, 16'hffec, 8'h00, 8'h00},
		{1'b0, 16'hffec, 8'h00, 8'h00}, {1'b1, 16'hffed, 8'hfe, 8'h00},
		{1'b1, 16'hffef, 8'h7f, 8'h00}, {1'b0, 16'hffef, 8'h00, 8'h7f},
		{1'b0, 16'hfff4, 8'h00, 8'h00}};
	always #2.5 clk_i = ~clk_i;
	ebac_top uut (.*);
	ebac_ext_model u_ext (.clk_i(clk_i), .rst_i(rst_i), .addr_strobe_n_i(addr_strobe_n_o),
		.stall_len_i(stall_len), .want_bus_i(want_bus), .wait_req_n_o(wait_req_n_i),
		.bus_request_n_o(ext_bus_request_n_i));
	// ==========================================
	// Tasks
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Classic cycle; hold everything until ack is sampled high
	task automatic wb(input logic we, input logic [15:0] a, input logic [7:0] d);
		int t;
		t = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 1'b1;
		do begin
			@(posedge clk_i);
			t++;
		end while (wb_ack_o !== 1'b1 && t < 50);
		if (wb_ack_o !== 1'b1) begin
			failures++;
			$display("[ERR] %0t register access not acknowledged", $time);
		end
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : wb
	// Access on both lanes; length counted in edges up to done
	task automatic acc(input logic [23:0] a, input logic we);
		@(posedge clk_i);
		acc_req_i <= 1'b1;
		acc_we_i <= we;
		acc_addr_i <= a;
		acc_upper_i <= 1'b1;
		acc_lower_i <= 1'b1;
		{n, seen_rd, seen_up, seen_lo, seen_sel7} = '0;
		do begin
			@(posedge clk_i);
			n++;
			seen_rd |= !read_strobe_n_o;
			seen_up |= !upper_write_strobe_n_o;
			seen_lo |= !lower_write_strobe_n_o;
			seen_sel7 |= !area_select_n_o[7];
		end while (acc_done_o !== 1'b1 && n < 100);
		if (acc_done_o !== 1'b1) begin
			failures++;
			$display("[ERR] %0t access never finished", $time);
		end
		acc_req_i <= 1'b0;
	endtask : acc
	task automatic print_verdict();
		if (failures == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : print_verdict
	// ==========================================
	// Main sequence
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		chk({6'h0, bus_8bit_mode_o, req_pins_as_io_o}, 8'h03);
		foreach (rows[i]) begin
			wb(rows[i].we, rows[i].a, rows[i].d);
			if (!rows[i].we) chk(q, rows[i].e);
		end
		chk({7'h0, bus_8bit_mode_o}, 8'h00);
		acc(24'h000100, 1'b0);
		n2 = n;
		chk({5'h0, seen_rd, seen_up, seen_lo}, 8'h04);
		acc(24'h200100, 1'b1);
		chk(8'(n - n2), 8'h01);
		chk({5'h0, seen_rd, seen_up, seen_lo}, 8'h03);
		// Every wait mode with two programmed waits; no-wait mode adds none
		for (int m = 0; m < 4; m++) begin
			wb(1'b1, 16'hffee, 8'hf2 | 8'(m << 2));
			acc(24'h200100, 1'b0);
			chk(8'(n - n2), (m == 1) ? 8'h01 : 8'h03);
		end
		stall_len <= 4'h6;
		acc(24'h200100, 1'b0);
		chk(8'(n > n2 + 3), 8'h01);
		acc(24'h000100, 1'b0);
		chk(8'(n - n2), 8'h00);
		acc(24'he00100, 1'b0);
		chk(8'(n > n2 + 1), 8'h01);
		stall_len <= 4'h0;
		acc(24'he00100, 1'b0);
		chk(8'(n - n2), 8'h01);
		acc(24'hfff100, 1'b0);
		chk(8'(n - n2), 8'h00);
		chk({4'h0, seen_sel7, seen_rd, seen_up, seen_lo}, 8'h08);
		mode_16m_i <= 1'b0;
		acc(24'h020100, 1'b0);
		chk(8'(n - n2), 8'h03);
		mode_16m_i <= 1'b1;
		// Bus request refused, then granted once release is enabled
		want_bus <= 1'b1;
		repeat (12) @(posedge clk_i);
		chk({7'h0, ext_bus_ack_n_o}, 8'h01);
		want_bus <= 1'b0;
		wb(1'b1, 16'hfff3, 8'h01);
		want_bus <= 1'b1;
		repeat (12) @(posedge clk_i);
		chk({4'h0, ext_bus_ack_n_o, req_pins_as_io_o, bus_owner_o}, 8'h03);
		want_bus <= 1'b0;
		repeat (12) @(posedge clk_i);
		chk({7'h0, ext_bus_ack_n_o}, 8'h01);
		// Refresh outranks the dma engine, which outranks the processor
		refresh_req_i <= 1'b1;
		dma_req_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk({6'h0, bus_owner_o}, 8'h02);
		refresh_req_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk({6'h0, bus_owner_o}, 8'h01);
		dma_req_i <= 1'b0;
		// Second reset with the 16-bit strap
		rst_i <= 1'b1;
		mode_8bit_default_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		wb(1'b0, 16'hffec, 8'h00);
		chk(q, 8'h00);
		wb(1'b0, 16'hfff3, 8'h00);
		chk(q, 8'hfe);
		print_verdict();
	end
	// Watchdog: the sequence needs well under 2000 cycles
	initial begin
		#100000;
		failures++;
		print_verdict();
	end
endmodule : ebac_top_tb
